// ### logic/pfs_top.sv
// two-channel pulse-width / serialiser output controller with shared fifo on apb
// Function
// - full flag high when fifo has no free entry; empty flag high when empty, reset 1.
// - write to full fifo sets sticky write error, bit 2, write-one clears.
// - pop attempt on empty fifo sets sticky read error, bit 3, write-one clears, unless repeat-last resends the last fifo word.
// - channel waiting on empty fifo after a fifo word sets its gap flag, unless repeat-last is enabled.
// - repeated writes to one register, other than status and fifo port, closer than the settling window set sticky bus error, bit 8.
// - read-only activity bits 9 and 10 show each channel transmitting.
// - dma requests issued only while dma enable bit 31 is set, reset 0.
// - dma config holds request threshold 7:0 and urgent threshold 15:8, reset 7.
// - each channel has a 32-bit period register resetting to 32.
// - serial mode truncates to period bits or pads after 32 bits.
// - pulse mode spreads value high cycles evenly across the period, or sends them as one block from the period start when msen is set.
// - each channel has a 32-bit value register, the source when fifo unused.
// - write-only fifo port pushes one word per write; reads return zero.
// - with both channels sharing, fifo words go alternately, channel 1 first.
// - sharing channels fetch in lock-step; shorter period waits for its turn.
// - writing one to control bit 6 flushes the fifo; reads back zero.
// - repeat-last resends last fifo word while the fifo stays empty.
// - per-channel source select picks fifo when 1, value register when 0.
`timescale 1ns/1ps
module pfs_top
	import pfs_pkg::*;
(
	input  wire logic                        sys_clk,
	input  wire logic                        nrst,
	input  wire logic                        ce,
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [pfs_pkg::ADDR_W-1:0]  paddr,
	input  wire logic [pfs_pkg::DATA_W-1:0]  pwdata,
	output logic      [pfs_pkg::DATA_W-1:0]  prdata,
	output logic                             pready,
	output logic                             pslverr,
	output logic      [1:0]                  pwm_out,
	output logic                             dma_req,
	output logic                             dma_urgent
);
	import pfs_pkg::*;

	pfs_ch_ctl_s            ch_ctl    [2];
	pfs_dma_cfg_s           dma_cfg;
	logic [31:0]            period    [2];
	logic [31:0]            value     [2];
	logic [31:0]            word      [2];
	logic [31:0]            cnt       [2];
	logic [32:0]            acc       [2];
	pfs_ch_state_e          st        [2];
	logic [1:0]             had_word;
	logic [DATA_W-1:0]      mem       [FIFO_DEPTH];
	logic [FIFO_AW-1:0]     wr_ptr;
	logic [FIFO_AW-1:0]     rd_ptr;
	logic [CNT_W-1:0]       level;
	logic                   turn;
	logic                   werr;
	logic                   rerr;
	logic [1:0]             gap;
	logic                   bus_sync_error_flag;
	logic [2:0]             guard;
	logic [ADDR_W-1:0]      last_wa;

	logic                   access;
	logic                   wr;
	logic [ADDR_W-1:0]      wa;
	logic                   mapped;
	logic [DATA_W-1:0]      rd_word;
	logic [DATA_W-1:0]      clr;
	logic                   flush;
	logic                   full;
	logic                   empty;
	logic                   push;
	logic                   pop;
	logic                   share;
	logic [1:0]             want;
	logic [1:0]             pop_v;
	logic [1:0]             rep_v;
	logic [1:0]             rerr_ev;
	logic [1:0]             gap_ev;
	logic [1:0]             last_cyc;
	logic [1:0]             ch_bit;
	logic [32:0]            next_acc  [2];
	logic                   werr_ev;
	logic                   bus_sync_error_flag_ev;

	// apb access phase, answered one cycle later
	assign access = psel & penable & ~pready;
	assign wr     = access & pwrite;
	assign wa     = paddr;

	assign full  = (level == FIFO_FULL_CNT);
	assign empty = (level == '0);
	assign flush = wr && (wa == CTRL_OFS) && pwdata[FLUSH_BIT];
	assign clr   = (wr && (wa == STATUS_OFS)) ? pwdata : '0;
	assign werr_ev = wr && (wa == FIFO_PORT_OFS) && full;
	assign push    = wr && (wa == FIFO_PORT_OFS) && !full;
	assign bus_sync_error_flag_ev = wr && (guard != 3'h0) && (wa == last_wa) && (wa != STATUS_OFS)
		&& (wa != FIFO_PORT_OFS);

	always_comb begin
		mapped  = 1'b1;
		rd_word = '0;
		unique case (wa)
			CTRL_OFS: begin
				rd_word[CH1_CTL_LSB +: 8] = ch_ctl[0];
				rd_word[CH2_CTL_LSB +: 8] = ch_ctl[1];
			end
			STATUS_OFS: begin
				rd_word[ST_FULL_BIT]  = full;
				rd_word[ST_EMPTY_BIT] = empty;
				rd_word[ST_WERR_BIT]  = werr;
				rd_word[ST_RERR_BIT]  = rerr;
				rd_word[ST_GAP1_BIT]  = gap[0];
				rd_word[ST_GAP2_BIT]  = gap[1];
				rd_word[ST_BUS_SYNC_ERROR_FLAG_BIT]  = bus_sync_error_flag;
				rd_word[ST_ACT1_BIT]  = (st[0] == CH_SEND);
				rd_word[ST_ACT2_BIT]  = (st[1] == CH_SEND);
			end
			DMA_CFG_OFS:    rd_word = dma_cfg;
			CH1_PERIOD_OFS: rd_word = period[0];
			CH1_VALUE_OFS:  rd_word = value[0];
			FIFO_PORT_OFS:  rd_word = '0;
			CH2_PERIOD_OFS: rd_word = period[1];
			CH2_VALUE_OFS:  rd_word = value[1];
			default:        mapped  = 1'b0;
		endcase
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= '0;
		end else if (ce) begin
			pready  <= access;
			pslverr <= access & ~mapped;
			prdata  <= (access && !pwrite) ? rd_word : '0;
		end
	end

	// control, dma configuration, period and value registers
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			ch_ctl[0] <= '0;
			ch_ctl[1] <= '0;
			dma_cfg   <= '{dma_request_enable: 1'b0, spare: '0,
				urgent_threshold: THR_RST, dma_req_threshold: THR_RST};
			period[0] <= PERIOD_RST;
			period[1] <= PERIOD_RST;
			value[0]  <= VALUE_RST;
			value[1]  <= VALUE_RST;
		end else if (ce && wr) begin
			unique case (wa)
				CTRL_OFS: begin
					ch_ctl[0]       <= pwdata[CH1_CTL_LSB +: 8];
					ch_ctl[0].spare <= 1'b0;
					ch_ctl[1]       <= pwdata[CH2_CTL_LSB +: 8];
					ch_ctl[1].spare <= 1'b0;
				end
				DMA_CFG_OFS: begin
					dma_cfg.dma_request_enable <= pwdata[DMA_EN_BIT];
					dma_cfg.urgent_threshold   <= pwdata[URGENT_LSB +: 8];
					dma_cfg.dma_req_threshold  <= pwdata[DMA_REQ_LSB +: 8];
				end
				CH1_PERIOD_OFS: period[0] <= pwdata;
				CH1_VALUE_OFS:  value[0]  <= pwdata;
				CH2_PERIOD_OFS: period[1] <= pwdata;
				CH2_VALUE_OFS:  value[1]  <= pwdata;
				default: begin
				end
			endcase
		end
	end

	// fifo hand-out: alternate turns while both channels share
	always_comb begin
		share = ch_ctl[0].pwen & ch_ctl[0].fifo_source_select
			& ch_ctl[1].pwen & ch_ctl[1].fifo_source_select;
		pop_v   = 2'b00;
		rep_v   = 2'b00;
		rerr_ev = 2'b00;
		gap_ev  = 2'b00;
		for (int ch = 0; ch < 2; ch++) begin
			want[ch] = ch_ctl[ch].pwen && ch_ctl[ch].fifo_source_select && (st[ch] == CH_WAIT)
				&& (!share || (turn == ch[0]));
			if (want[ch] && empty) begin
				if (ch_ctl[ch].repeat_last_enable && had_word[ch]) begin
					rep_v[ch] = 1'b1;
				end else begin
					rerr_ev[ch] = 1'b1;
				end
			end
			gap_ev[ch] = ch_ctl[ch].pwen && ch_ctl[ch].fifo_source_select && (st[ch] == CH_WAIT) && empty
				&& had_word[ch] && !ch_ctl[ch].repeat_last_enable;
		end
		if (want[0] && !empty) begin
			pop_v[0] = 1'b1;
		end else if (want[1] && !empty) begin
			pop_v[1] = 1'b1;
		end
		pop = |pop_v;
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			level  <= '0;
			turn   <= 1'b0;
		end else if (ce) begin
			if (flush) begin
				wr_ptr <= '0;
				rd_ptr <= '0;
				level  <= '0;
				turn   <= 1'b0;
			end else begin
				if (push) begin
					wr_ptr <= wr_ptr + 3'h1;
				end
				if (pop) begin
					rd_ptr <= rd_ptr + 3'h1;
				end
				level <= level + CNT_W'(push) - CNT_W'(pop);
				if (!share) begin
					turn <= 1'b0;
				end else if (pop) begin
					turn <= ~turn;
				end
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (ce && push) begin
			mem[wr_ptr] <= pwdata;
		end
	end

	// sticky flags: a set in the clearing cycle wins
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			werr <= 1'b0;
			rerr <= 1'b0;
			gap  <= 2'b00;
			bus_sync_error_flag <= 1'b0;
		end else if (ce) begin
			werr <= (werr & ~clr[ST_WERR_BIT]) | werr_ev;
			rerr <= (rerr & ~clr[ST_RERR_BIT]) | (|rerr_ev);
			gap  <= (gap & ~clr[ST_GAP2_BIT:ST_GAP1_BIT]) | gap_ev;
			bus_sync_error_flag <= (bus_sync_error_flag & ~clr[ST_BUS_SYNC_ERROR_FLAG_BIT]) | bus_sync_error_flag_ev;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			guard   <= 3'h0;
			last_wa <= '0;
		end else if (ce) begin
			if (wr) begin
				guard   <= SYNC_GUARD_CYC;
				last_wa <= wa;
			end else if (guard != 3'h0) begin
				guard <= guard - 3'h1;
			end
		end
	end

	// per-cycle output bit for each channel
	always_comb begin
		for (int ch = 0; ch < 2; ch++) begin
			last_cyc[ch] = ({1'b0, cnt[ch]} + 33'h1) >= {1'b0, period[ch]};
			next_acc[ch] = acc[ch] + {1'b0, word[ch]};
			if (ch_ctl[ch].serialiser_select) begin
				ch_bit[ch] = (cnt[ch] < 32'(SERIAL_BITS))
					? word[ch][5'h1f - cnt[ch][4:0]] : ch_ctl[ch].sbit;
			end else if (ch_ctl[ch].msen) begin
				ch_bit[ch] = (cnt[ch] < word[ch]);
			end else if (word[ch] >= period[ch]) begin
				ch_bit[ch]   = 1'b1;
				next_acc[ch] = '0;
			end else if (next_acc[ch] >= {1'b0, period[ch]}) begin
				ch_bit[ch]   = 1'b1;
				next_acc[ch] = next_acc[ch] - {1'b0, period[ch]};
			end else begin
				ch_bit[ch] = 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			for (int ch = 0; ch < 2; ch++) begin
				st[ch]   <= CH_IDLE;
				cnt[ch]  <= '0;
				acc[ch]  <= '0;
				word[ch] <= '0;
			end
			had_word <= 2'b00;
		end else if (ce) begin
			for (int ch = 0; ch < 2; ch++) begin
				if (!ch_ctl[ch].pwen || (flush && ch_ctl[ch].fifo_source_select)) begin
					st[ch]       <= ch_ctl[ch].pwen ? CH_WAIT : CH_IDLE;
					had_word[ch] <= 1'b0;
				end else begin
					unique case (st[ch])
						CH_IDLE: st[ch] <= CH_WAIT;
						CH_WAIT: begin
							cnt[ch] <= '0;
							acc[ch] <= '0;
							if (!ch_ctl[ch].fifo_source_select) begin
								word[ch] <= value[ch];
								st[ch]   <= CH_SEND;
							end else if (pop_v[ch]) begin
								word[ch]     <= mem[rd_ptr];
								had_word[ch] <= 1'b1;
								st[ch]       <= CH_SEND;
							end else if (rep_v[ch]) begin
								st[ch] <= CH_SEND;
							end
						end
						CH_SEND: begin
							cnt[ch] <= cnt[ch] + 32'h1;
							acc[ch] <= next_acc[ch];
							if (last_cyc[ch]) begin
								st[ch] <= CH_WAIT;
							end
						end
						default: st[ch] <= CH_IDLE;
					endcase
				end
			end
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			pwm_out <= 2'b00;
		end else if (ce) begin
			for (int ch = 0; ch < 2; ch++) begin
				pwm_out[ch] <= ((st[ch] == CH_SEND) ? ch_bit[ch] : ch_ctl[ch].sbit) ^ ch_ctl[ch].pola;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			dma_req    <= 1'b0;
			dma_urgent <= 1'b0;
		end else if (ce) begin
			dma_req    <= dma_cfg.dma_request_enable
				&& ({4'h0, level} <= dma_cfg.dma_req_threshold);
			dma_urgent <= dma_cfg.dma_request_enable
				&& ({4'h0, level} <= dma_cfg.urgent_threshold);
		end
	end

endmodule

// ### logic/pfs_pkg.sv
// constants, types and register map of the two-channel pulse/serial output block
package pfs_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// register byte offsets
	localparam logic [ADDR_W-1:0] CTRL_OFS       = 8'h00;
	localparam logic [ADDR_W-1:0] STATUS_OFS     = 8'h04;
	localparam logic [ADDR_W-1:0] DMA_CFG_OFS    = 8'h08;
	localparam logic [ADDR_W-1:0] CH1_PERIOD_OFS = 8'h10;
	localparam logic [ADDR_W-1:0] CH1_VALUE_OFS  = 8'h14;
	localparam logic [ADDR_W-1:0] FIFO_PORT_OFS  = 8'h18;
	localparam logic [ADDR_W-1:0] CH2_PERIOD_OFS = 8'h20;
	localparam logic [ADDR_W-1:0] CH2_VALUE_OFS  = 8'h24;

	// shared transmit fifo
	localparam int FIFO_DEPTH = 8;
	localparam int FIFO_AW    = 3;
	localparam int CNT_W      = 4;
	localparam logic [CNT_W-1:0] FIFO_FULL_CNT = 4'h8;

	// field positions
	localparam int CH1_CTL_LSB = 0;
	localparam int CH2_CTL_LSB = 8;
	localparam int FLUSH_BIT   = 6;
	localparam int ST_FULL_BIT  = 0;
	localparam int ST_EMPTY_BIT = 1;
	localparam int ST_WERR_BIT  = 2;
	localparam int ST_RERR_BIT  = 3;
	localparam int ST_GAP1_BIT  = 4;
	localparam int ST_GAP2_BIT  = 5;
	localparam int ST_BUS_SYNC_ERROR_FLAG_BIT  = 8;
	localparam int ST_ACT1_BIT  = 9;
	localparam int ST_ACT2_BIT  = 10;
	localparam int DMA_EN_BIT   = 31;
	localparam int DMA_REQ_LSB  = 0;
	localparam int URGENT_LSB   = 8;
	localparam int SERIAL_BITS  = 32;

	// reset values
	localparam logic [31:0] PERIOD_RST = 32'h0000_0020;
	localparam logic [31:0] VALUE_RST  = 32'h0000_0000;
	localparam logic [7:0]  THR_RST    = 8'h07;

	// settling window of a register write
	localparam int CLK_PERIOD_NS  = 10;
	localparam int SYNC_GUARD_NS  = 40;
	localparam logic [2:0] SYNC_GUARD_CYC = 3'((SYNC_GUARD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	typedef enum logic [1:0] {
		CH_IDLE = 2'b00,
		CH_WAIT = 2'b01,
		CH_SEND = 2'b10
	} pfs_ch_state_e;

	typedef struct packed {
		logic msen;
		logic spare;
		logic fifo_source_select;
		logic pola;
		logic sbit;
		logic repeat_last_enable;
		logic serialiser_select;
		logic pwen;
	} pfs_ch_ctl_s;

	typedef struct packed {
		logic       dma_request_enable;
		logic [14:0] spare;
		logic [7:0] urgent_threshold;
		logic [7:0] dma_req_threshold;
	} pfs_dma_cfg_s;

endpackage

// ### testbench/pfs_props.sv
// bus answer, read-back and dma gating properties of pfs_top
`timescale 1ns/1ps
module pfs_props
	import pfs_pkg::*;
(
	input wire logic			sys_clk,
	input wire logic			nrst,
	input wire logic			ce,
	input wire logic			psel,
	input wire logic			penable,
	input wire logic			pwrite,
	input wire logic [pfs_pkg::ADDR_W-1:0]	paddr,
	input wire logic [pfs_pkg::DATA_W-1:0]	pwdata,
	input wire logic [pfs_pkg::DATA_W-1:0]	prdata,
	input wire logic			pready,
	input wire logic			pslverr,
	input wire logic [1:0]			pwm_out,
	input wire logic			dma_req,
	input wire logic			dma_urgent
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!nrst);
	logic	tk;
	logic	mp;
	logic	en_q;
	assign tk = psel && penable && !pready && ce;
	assign mp = paddr inside {CTRL_OFS, STATUS_OFS, DMA_CFG_OFS, CH1_PERIOD_OFS, CH1_VALUE_OFS,
		FIFO_PORT_OFS, CH2_PERIOD_OFS, CH2_VALUE_OFS};
	// shadow of the dma enable bit
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			en_q <= 1'b0;
		end else if (tk && pwrite && paddr == DMA_CFG_OFS) begin
			en_q <= pwdata[DMA_EN_BIT];
		end
	end
	sequence s_rd(a);
		tk && !pwrite && paddr == a;
	endsequence
	a_answer_next: assert property (tk |=> pready && !$past(pready))
		else $error("no answer after access");
	a_ready_cause: assert property (pready |-> $past(tk))
		else $error("answer without access");
	a_idle_zero: assert property (!pready |-> prdata == '0)
		else $error("read data outside answer");
	a_unmapped_err: assert property (tk && !mp |=> pslverr)
		else $error("unmapped access accepted");
	a_fifo_rd_zero: assert property (s_rd(FIFO_PORT_OFS) |=> prdata == '0)
		else $error("fifo port read not zero");
	a_flush_rd_zero: assert property (s_rd(CTRL_OFS) |=> !prdata[FLUSH_BIT])
		else $error("flush bit reads one");
	a_status_rsvd: assert property (s_rd(STATUS_OFS) |=> prdata[31:11] == '0 && prdata[7:6] == '0)
		else $error("reserved status bits set");
	a_dma_gated: assert property (!en_q && !$past(en_q) |-> !dma_req && !dma_urgent)
		else $error("dma request while disabled");
endmodule

bind pfs_top pfs_props i_pfs_props (.sys_clk(sys_clk), .nrst(nrst), .ce(ce), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .pwm_out(pwm_out), .dma_req(dma_req), .dma_urgent(dma_urgent));

// ### testbench/pfs_apb_host.sv
// apb master standing in for the processor and dma controller
`timescale 1ns/1ps
module pfs_apb_host
	import pfs_pkg::*;
(
	input wire logic			sys_clk,
	input wire logic [pfs_pkg::DATA_W-1:0]	prdata,
	input wire logic			pready,
	input wire logic			pslverr,
	output logic				psel,
	output logic				penable,
	output logic				pwrite,
	output logic [pfs_pkg::ADDR_W-1:0]	paddr,
	output logic [pfs_pkg::DATA_W-1:0]	pwdata
);
	bit	tmo;
	bit	hold;
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
	end
	// bb keeps psel up so the next transfer starts at the answer edge
	task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
		output logic [DATA_W-1:0] q, output logic e, input bit bb);
		int n;
		n = 0;
		if (!hold) @(posedge sys_clk);
		hold = bb;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		tmo = pready !== 1'b1;
		q = prdata;
		e = pslverr;
		if (!bb) begin
			psel <= 1'b0;
			penable <= 1'b0;
			paddr <= ~a;
			pwdata <= ~d;
		end
	endtask
endmodule

// ### testbench/testbench.sv
// self-checking bench for the pulse/serial output block
`timescale 1ns/1ps
`define CHK(g, x) begin n_tests++; if ((g) !== (x)) begin n_fail++; $display("unexpected %0t: %h vs %h", $time, (g), (x)); end end
module testbench;
	import pfs_pkg::*;
	logic		sys_clk;
	logic		nrst;
	logic		ce;
	logic		psel;
	logic		penable;
	logic		pwrite;
	logic [7:0]	paddr;
	logic [31:0]	pwdata;
	logic [31:0]	prdata;
	logic		pready;
	logic		pslverr;
	logic [1:0]	pwm_out;
	logic		dma_req;
	logic		dma_urgent;
	logic [31:0]	q;
	logic		e;
	int		n_fail;
	int		n_tests;
	int		c0;
	int		c1;
	pfs_top i_pfs_top (.sys_clk(sys_clk), .nrst(nrst), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pwm_out(pwm_out), .dma_req(dma_req), .dma_urgent(dma_urgent));
	pfs_apb_host i_pfs_apb_host (.sys_clk(sys_clk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0 && !i_pfs_apb_host.tmo) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input bit bb = 1'b0);
		i_pfs_apb_host.xfer(1'b1, a, d, q, e, bb);
		if (i_pfs_apb_host.tmo) begin
			n_fail++;
			$display("unexpected %0t: bus write timeout", $time);
			give_verdict();
		end
	endtask
	task automatic ck(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m = '1);
		i_pfs_apb_host.xfer(1'b0, a, 32'h0, q, e, 1'b0);
		if (i_pfs_apb_host.tmo) begin
			n_fail++;
			$display("unexpected %0t: bus read timeout", $time);
			give_verdict();
		end
		`CHK(q & m, x)
	endtask
	// counts high cycles per output pin
	task automatic ones(input int n, input bit clr);
		if (clr) begin
			c0 = 0;
			c1 = 0;
		end
		repeat (n) begin
			@(negedge sys_clk);
			c0 += int'(pwm_out[0] === 1'b1);
			c1 += int'(pwm_out[1] === 1'b1);
		end
	endtask
	initial begin
		nrst = 1'b0;
		ce = 1'b1;
		n_fail = 0;
		n_tests = 0;
		repeat (2) @(posedge sys_clk);
		nrst <= 1'b1;
		ck(STATUS_OFS, 32'h2);
		ck(DMA_CFG_OFS, 32'h707);
		ck(CH1_PERIOD_OFS, 32'h20);
		ck(CH2_PERIOD_OFS, 32'h20);
		ck(CH1_VALUE_OFS, 32'h0);
		ck(CTRL_OFS, 32'h0);
		i_pfs_apb_host.xfer(1'b0, 8'h0c, 32'h0, q, e, 1'b0);
		`CHK(e, 1'b1)
		$display("test reset done");
		wr(DMA_CFG_OFS, 32'h8000_0103);
		@(negedge sys_clk);
		`CHK({dma_req, dma_urgent}, 2'b11)
		wr(FIFO_PORT_OFS, 32'h1);
		wr(FIFO_PORT_OFS, 32'h2);
		@(negedge sys_clk);
		`CHK({dma_req, dma_urgent}, 2'b10)
		for (int i = 0; i < 6; i++) wr(FIFO_PORT_OFS, 32'(i));
		@(negedge sys_clk);
		`CHK({dma_req, dma_urgent}, 2'b00)
		ck(STATUS_OFS, 32'h1, 32'h3);
		wr(FIFO_PORT_OFS, 32'h9);
		ck(STATUS_OFS, 32'h5, 32'h7);
		ck(FIFO_PORT_OFS, 32'h0);
		wr(CH2_PERIOD_OFS, 32'h8, 1'b1);
		wr(CH2_PERIOD_OFS, 32'h8);
		wr(STATUS_OFS, 32'h0);
		ck(STATUS_OFS, 32'h104, 32'h104);
		wr(STATUS_OFS, 32'h104);
		ck(STATUS_OFS, 32'h0, 32'h104);
		wr(CTRL_OFS, 32'h40);
		ck(STATUS_OFS, 32'h2, 32'h3);
		ck(CTRL_OFS, 32'h0);
		@(negedge sys_clk);
		`CHK(dma_req, 1'b1)
		wr(DMA_CFG_OFS, 32'h0);
		repeat (2) @(negedge sys_clk);
		`CHK(dma_req, 1'b0)
		$display("test fifo done");
		wr(CH1_VALUE_OFS, 32'hffff_ffff);
		wr(CH1_PERIOD_OFS, 32'd60);
		wr(CTRL_OFS, 32'h3);
		ones(16, 1'b1);
		ck(STATUS_OFS, 32'h200, 32'h600);
		ones(61, 1'b1);
		`CHK(c0, 32)
		wr(CTRL_OFS, 32'h40);
		wr(CH1_PERIOD_OFS, 32'h4);
		wr(FIFO_PORT_OFS, 32'hffff_ffff);
		wr(CTRL_OFS, 32'h23);
		ones(20, 1'b1);
		`CHK(c0, 4)
		ck(STATUS_OFS, 32'h1a, 32'h1f);
		wr(CTRL_OFS, 32'h40);
		wr(STATUS_OFS, 32'h3c);
		wr(FIFO_PORT_OFS, 32'hffff_ffff);
		wr(CTRL_OFS, 32'h27);
		ones(30, 1'b1);
		`CHK(c0 > 4, 1'b1)
		ck(STATUS_OFS, 32'h0, 32'h10);
		$display("test serial done");
		wr(CTRL_OFS, 32'h40);
		wr(STATUS_OFS, 32'h3c);
		wr(CH1_PERIOD_OFS, 32'h8);
		wr(CH2_PERIOD_OFS, 32'h8);
		wr(FIFO_PORT_OFS, 32'hff00_0000);
		wr(FIFO_PORT_OFS, 32'hf000_0000);
		wr(CTRL_OFS, 32'h2323);
		ones(40, 1'b1);
		`CHK(c0, 8)
		`CHK(c1, 4)
		ck(STATUS_OFS, 32'h3a, 32'h3f);
		$display("test share done");
		wr(CTRL_OFS, 32'h40);
		wr(CH1_VALUE_OFS, 32'h3);
		wr(CH2_VALUE_OFS, 32'h3);
		wr(CTRL_OFS, 32'h9101);
		ones(5, 1'b1);
		ones(9, 1'b1);
		`CHK(c0, 3)
		`CHK(c1, 6)
		$display("test pulse done");
		give_verdict();
	end
endmodule
